// ==== verilog/pic_ctrl.sv ====
// prioritizing interrupt controller core with register port
//
// Overview of operation
// - five 16-bit read/write level registers, four 4-bit level fields each.
// - fields map pins 0-7, dma pairs, timers, serial, parity, watchdog.
// - field value 0 is lowest level, 15 is highest.
// - two sources sharing one field always use the same level.
// - reset clears level registers; standby leaves them unchanged.
// - lowest field of fifth level register reads zero; software writes zero.
// - 16-bit control register reset-initialised, kept through standby.
// - control bit 15 is read-only non-maskable pin level.
// - control bits 14-9 read zero; software writes zero.
// - control bit 8 picks non-maskable edge: 0 falling, 1 rising.
// - control bits 7-0 pick pins 0-7 sensing: 0 low level, 1 falling edge.
// - highest programmed level among pending requests wins.
// - equal levels resolved by fixed ranking order.
// - forward only when level strictly exceeds CPU mask level; nmi is always forwarded.
// - accepting a request drives the acknowledge pin low.
// - acknowledge pin returns high on take-over or mask update.
// - edge-detected request latched once until accepted.
// - level and peripheral requests pending only while asserted.
`timescale 1ns/1ps
`default_nettype none
module pic_ctrl
    import pic_pkg::*;
(
    input  wire logic                         mclk_in,        // 25 MHz clock
    input  wire logic                         sys_rst_in,     // async reset
    input  wire logic                         ce_in,          // clock enable
    input  wire logic [pic_pkg::PIC_ADDR_W-1:0] addr_in,      // reg index
    input  wire logic [15:0]                  wr_data_in,     // write data
    input  wire logic                         wr_en_in,       // write strobe
    input  wire logic                         rd_en_in,       // read strobe
    output logic      [15:0]                  rd_data_out,    // read data
    input  wire logic [7:0]                   ext_req_n_in,   // pins 0-7
    input  wire logic                         nmi_in,         // nmi pin
    input  wire logic [pic_pkg::PIC_NUM_PERIPH-1:0] periph_req_in, // units
    input  wire logic [3:0]                   cpu_mask_level_in, // cpu mask
    input  wire logic                         cpu_take_in,    // exc. start
    output logic                              int_req_out,    // to cpu
    output logic      [3:0]                   int_level_out,  // winner level
    output logic      [pic_pkg::PIC_SRC_W-1:0] int_src_out,   // winner id
    output logic                              irq_ack_out_n   // ack pin
);
    import pic_pkg::*;

    pic_state_s st_r;
    pic_state_s st_nxt;

    // field index serving each source in ranking order
    function automatic logic [4:0] src_field(input int idx);
        logic [4:0] f;
        f = 5'h00;
        if (idx < 8)
            f = 5'(idx);                    // pins 0-7
        else if (idx < 12)
            f = 5'(8 + (idx - 8) / 2);      // dma pairs
        else if (idx < 27)
            f = 5'(10 + (idx - 12) / 3);    // timer channels
        else if (idx < 35)
            f = 5'(15 + (idx - 27) / 4);    // serial ports
        else if (idx == 35)
            f = 5'h11;                      // parity unit
        else
            f = 5'h12;                      // watchdog and refresh
        return f;
    endfunction

    // level of one field, top field of register first
    function automatic logic [3:0] fld_level(
        input logic [PIC_NUM_PRIO-1:0][15:0] pr,
        input logic [4:0]                    f);
        logic [15:0] w;
        logic [1:0]  pos;
        w   = pr[f[4:2]];
        pos = 2'd3 - f[1:0];
        return w[pos*PIC_FLD_W +: PIC_FLD_W];
    endfunction

    // next-state logic, frozen while the clock enable is low
    always_comb begin
        logic [PIC_NUM_SRC-1:0] pend;
        logic [3:0]             best_lvl;
        logic [5:0]             best_src;
        logic                   found;
        logic [7:0]             fall;
        logic [7:0]             sense;
        logic                   nmi_edge;
        pend     = '0;
        best_lvl = 4'h0;
        best_src = 6'h00;
        found    = 1'b0;
        fall     = 8'h00;
        sense    = 8'h00;
        nmi_edge = 1'b0;
        st_nxt   = st_r;
        if (ce_in) begin
            // three-stage sync, change taken when stages 2 and 3 agree
            st_nxt.s1 = {nmi_in, ext_req_n_in};
            st_nxt.s2 = st_r.s1;
            st_nxt.s3 = st_r.s2;
            for (int i = 0; i < PIC_SYNC_W; i++) begin
                if (st_r.s2[i] == st_r.s3[i])
                    st_nxt.filt[i] = st_r.s3[i];
            end
            // edge detection on filtered levels
            fall = st_r.filt[7:0] & ~st_nxt.filt[7:0];
            for (int i = 0; i < PIC_NUM_EXT; i++)
                sense[i] = st_r.ctrl[7-i];
            if (st_r.ctrl[PIC_NMI_EDGE_BIT])
                nmi_edge = ~st_r.filt[8] & st_nxt.filt[8];
            else
                nmi_edge = st_r.filt[8] & ~st_nxt.filt[8];
            // single pending latch per edge source, set beats clear
            for (int i = 0; i < PIC_NUM_EXT; i++) begin
                if (cpu_take_in && st_r.src == 6'(i + 1))
                    st_nxt.ext_lat[i] = 1'b0;
                if (fall[i] && sense[i])
                    st_nxt.ext_lat[i] = 1'b1;
            end
            if (cpu_take_in && st_r.src == PIC_SRC_NMI && st_r.req)
                st_nxt.nmi_lat = 1'b0;
            if (nmi_edge)
                st_nxt.nmi_lat = 1'b1;
            // register writes
            if (wr_en_in) begin
                unique case (addr_in)
                    PIC_IDX_PRIO_A, PIC_IDX_PRIO_B,
                    PIC_IDX_PRIO_C, PIC_IDX_PRIO_D:
                        st_nxt.prio[addr_in] = wr_data_in;
                    PIC_IDX_PRIO_E:
                        st_nxt.prio[PIC_IDX_PRIO_E] =
                            wr_data_in & PIC_PRIO_E_WMASK;
                    PIC_IDX_CTRL:
                        st_nxt.ctrl = wr_data_in[PIC_CTRL_W-1:0];
                    default: ;
                endcase
            end
            // read data stands one cycle after the strobe
            st_nxt.rdata = 16'h0000;
            if (rd_en_in) begin
                unique case (addr_in)
                    PIC_IDX_PRIO_A, PIC_IDX_PRIO_B, PIC_IDX_PRIO_C,
                    PIC_IDX_PRIO_D, PIC_IDX_PRIO_E:
                        st_nxt.rdata = st_r.prio[addr_in];
                    PIC_IDX_CTRL:
                        st_nxt.rdata = {st_r.filt[8], 6'h00,
                                        st_r.ctrl};
                    default: st_nxt.rdata = 16'h0000;
                endcase
            end
            // pending vector from updated latches and live levels
            for (int i = 0; i < PIC_NUM_EXT; i++)
                pend[i] = sense[i] ? st_nxt.ext_lat[i]
                                   : ~st_r.filt[i];
            pend[PIC_NUM_SRC-1:PIC_NUM_EXT] = periph_req_in;
            // highest level wins, earliest rank on a tie
            for (int i = 0; i < PIC_NUM_SRC; i++) begin
                if (pend[i] && (!found ||
                    fld_level(st_r.prio, src_field(i)) > best_lvl))
                begin
                    found    = 1'b1;
                    best_lvl = fld_level(st_r.prio, src_field(i));
                    best_src = 6'(i + 1);
                end
            end
            if (st_nxt.nmi_lat) begin
                found    = 1'b1;
                best_lvl = PIC_NMI_LEVEL;
                best_src = PIC_SRC_NMI;
            end
            // mask compare; nmi is never masked
            st_nxt.req   = found && (best_src == PIC_SRC_NMI ||
                                     best_lvl > cpu_mask_level_in);
            st_nxt.lvl   = best_lvl;
            st_nxt.src   = best_src;
            st_nxt.ack_n = ~st_nxt.req;
        end
    end

    // state register, reset to constants only
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_r         <= '0;
            st_r.prio    <= {PIC_NUM_PRIO{PIC_PRIO_RST}};
            st_r.ctrl    <= PIC_CTRL_RST;
            st_r.s1      <= '1;
            st_r.s2      <= '1;
            st_r.s3      <= '1;
            st_r.filt    <= '1;
            st_r.ack_n   <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flip-flops
    assign rd_data_out   = st_r.rdata;
    assign int_req_out   = st_r.req;
    assign int_level_out = st_r.lvl;
    assign int_src_out   = st_r.src;
    assign irq_ack_out_n = st_r.ack_n;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_wr_a;
        ce_in && wr_en_in && addr_in == PIC_IDX_PRIO_A;
    endsequence
    sequence s_rd_a;
        ce_in && rd_en_in && addr_in == PIC_IDX_PRIO_A;
    endsequence
    sequence s_rd_ctrl;
        ce_in && rd_en_in && addr_in == PIC_IDX_CTRL;
    endsequence

    property p_prio_rw;
        s_wr_a ##1 s_rd_a |=> rd_data_out == $past(wr_data_in, 2);
    endproperty
    a_prio_rw: assert property (p_prio_rw)
        else $error("level register did not hold written value");

    property p_rsv_field;
        ce_in && rd_en_in && addr_in == PIC_IDX_PRIO_E
            |=> rd_data_out[3:0] == 4'h0;
    endproperty
    a_rsv_field: assert property (p_rsv_field)
        else $error("reserved level field read nonzero");

    property p_ctrl_rsv;
        s_rd_ctrl |=> rd_data_out[14:9] == 6'h00;
    endproperty
    a_ctrl_rsv: assert property (p_ctrl_rsv)
        else $error("reserved control bits read nonzero");

    property p_nmi_level;
        s_rd_ctrl |=> rd_data_out[PIC_NMI_LVL_BIT] == $past(st_r.filt[8]);
    endproperty
    a_nmi_level: assert property (p_nmi_level)
        else $error("nmi level bit does not follow pin");

    property p_mask;
        $past(ce_in) && int_req_out && int_src_out != PIC_SRC_NMI
            |-> int_level_out > $past(cpu_mask_level_in);
    endproperty
    a_mask: assert property (p_mask)
        else $error("request forwarded at or below mask");

    property p_ack_pin;
        irq_ack_out_n == !int_req_out;
    endproperty
    a_ack_pin: assert property (p_ack_pin)
        else $error("ack pin disagrees with acceptance");

    property p_edge_hold;
        ce_in && st_r.ext_lat[0] && !cpu_take_in |=> st_r.ext_lat[0];
    endproperty
    a_edge_hold: assert property (p_edge_hold)
        else $error("edge request lost before acceptance");

    property p_nmi_wins;
        ce_in && st_r.nmi_lat && !cpu_take_in
            |=> int_req_out && int_src_out == PIC_SRC_NMI;
    endproperty
    a_nmi_wins: assert property (p_nmi_wins)
        else $error("pending nmi did not win selection");

    // write sequences for the remaining register checks
    sequence s_wr_e;
        ce_in && wr_en_in && addr_in == PIC_IDX_PRIO_E;
    endsequence
    sequence s_wr_ctrl;
        ce_in && wr_en_in && addr_in == PIC_IDX_CTRL;
    endsequence

    property p_rd_idle;
        ce_in && !rd_en_in |=> rd_data_out == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data left standing");

    property p_wr_e_low;
        s_wr_e |=> st_r.prio[PIC_IDX_PRIO_E][3:0] == 4'h0;
    endproperty
    a_wr_e_low: assert property (p_wr_e_low)
        else $error("reserved level field took a write");

    property p_ctrl_wr;
        s_wr_ctrl |=> st_r.ctrl == $past(wr_data_in[PIC_CTRL_W-1:0]);
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr)
        else $error("control register did not take write");

    // synchroniser and sensing checks
    property p_sync_hold;
        ce_in && st_r.s2[0] != st_r.s3[0] |=> $stable(st_r.filt[0]);
    endproperty
    a_sync_hold: assert property (p_sync_hold)
        else $error("filtered pin moved before stages agreed");

    property p_nmi_rise;
        ce_in && st_r.ctrl[PIC_NMI_EDGE_BIT] && !st_r.filt[8] &&
            st_nxt.filt[8] |=> st_r.nmi_lat;
    endproperty
    a_nmi_rise: assert property (p_nmi_rise)
        else $error("rising nmi edge not latched");

    property p_nmi_fall;
        ce_in && !st_r.ctrl[PIC_NMI_EDGE_BIT] && st_r.filt[8] &&
            !st_nxt.filt[8] |=> st_r.nmi_lat;
    endproperty
    a_nmi_fall: assert property (p_nmi_fall)
        else $error("falling nmi edge not latched");

    property p_take_clear;
        ce_in && cpu_take_in && int_src_out == 6'h01 &&
            st_nxt.filt[0] == st_r.filt[0] |=> !st_r.ext_lat[0];
    endproperty
    a_take_clear: assert property (p_take_clear)
        else $error("edge request kept after acceptance");

    // selection and forwarding checks
    property p_lvl_pin;
        ce_in && !st_r.ctrl[7] && !st_r.filt[0] &&
            st_r.prio[PIC_IDX_PRIO_A][15:12] > cpu_mask_level_in
            |=> int_req_out;
    endproperty
    a_lvl_pin: assert property (p_lvl_pin)
        else $error("low level pin not forwarded");

    property p_periph_req;
        ce_in && periph_req_in[0] &&
            st_r.prio[PIC_IDX_PRIO_C][15:12] > cpu_mask_level_in
            |=> int_req_out;
    endproperty
    a_periph_req: assert property (p_periph_req)
        else $error("peripheral request not forwarded");

    property p_quiet;
        ce_in && periph_req_in == '0 && st_r.filt[7:0] == 8'hFF &&
            st_nxt.ext_lat == 8'h00 && !st_nxt.nmi_lat |=> !int_req_out;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("request forwarded with nothing pending");

    property p_lvl_nonzero;
        int_req_out && int_src_out != PIC_SRC_NMI |-> int_level_out != 4'h0;
    endproperty
    a_lvl_nonzero: assert property (p_lvl_nonzero)
        else $error("level zero request forwarded");

    property p_dma_tie;
        $past(ce_in) && int_req_out && int_src_out == 6'h0A
            |-> !$past(periph_req_in[0]);
    endproperty
    a_dma_tie: assert property (p_dma_tie)
        else $error("shared field tie went to lower rank");

    property p_ack_high;
        ce_in && !st_nxt.req |=> irq_ack_out_n;
    endproperty
    a_ack_high: assert property (p_ack_high)
        else $error("ack pin low with no accepted request");

endmodule
`default_nettype wire

// ==== verilog/pic_pkg.sv ====
// constants and state type for the prioritizing interrupt controller
package pic_pkg;

    // register index on the plain register port
    localparam int          PIC_ADDR_W        = 3;
    localparam logic [2:0]  PIC_IDX_PRIO_A    = 3'h0;
    localparam logic [2:0]  PIC_IDX_PRIO_B    = 3'h1;
    localparam logic [2:0]  PIC_IDX_PRIO_C    = 3'h2;
    localparam logic [2:0]  PIC_IDX_PRIO_D    = 3'h3;
    localparam logic [2:0]  PIC_IDX_PRIO_E    = 3'h4;
    localparam logic [2:0]  PIC_IDX_CTRL      = 3'h5;

    // reset values
    localparam logic [15:0] PIC_PRIO_RST      = 16'h0000;
    localparam logic [8:0]  PIC_CTRL_RST      = 9'h000;

    // field positions
    localparam int          PIC_FLD_W         = 4;
    localparam int          PIC_NUM_PRIO      = 5;
    localparam int          PIC_NUM_FLD       = 20;
    localparam logic [15:0] PIC_PRIO_E_WMASK  = 16'hFFF0;
    localparam int          PIC_NMI_LVL_BIT   = 15;
    localparam int          PIC_NMI_EDGE_BIT  = 8;
    localparam int          PIC_CTRL_W        = 9;

    // source counts in fixed ranking order
    localparam int          PIC_NUM_EXT       = 8;
    localparam int          PIC_NUM_PERIPH    = 30;
    localparam int          PIC_NUM_SRC       = 38;
    localparam int          PIC_SRC_W         = 6;
    localparam logic [5:0]  PIC_SRC_NMI       = 6'h00;
    localparam logic [3:0]  PIC_NMI_LEVEL     = 4'hF;

    // synchroniser width for pin inputs: eight pins plus nmi
    localparam int          PIC_SYNC_W        = 9;

    // all state of the controller
    typedef struct packed {
        logic [PIC_NUM_PRIO-1:0][15:0] prio;
        logic [8:0]                    ctrl;
        logic [8:0]                    s1;
        logic [8:0]                    s2;
        logic [8:0]                    s3;
        logic [8:0]                    filt;
        logic [7:0]                    ext_lat;
        logic                          nmi_lat;
        logic                          req;
        logic [3:0]                    lvl;
        logic [5:0]                    src;
        logic                          ack_n;
        logic [15:0]                   rdata;
    } pic_state_s;

endpackage

// ==== verification/pic_cpu_model.sv ====
// cpu stand-in that accepts forwarded requests and loads its mask
`timescale 1ns/1ps
`default_nettype none
module pic_cpu_model (
    input  wire logic       clk_in,       // system clock
    input  wire logic       rst_in,       // async reset
    input  wire logic       int_req_in,   // forwarded request
    input  wire logic [3:0] int_level_in, // winner level
    input  wire logic       go_in,        // allow acceptance
    input  wire logic [3:0] dly_in,       // decode latency
    input  wire logic       mask_ld_in,   // software mask load
    input  wire logic [3:0] mask_val_in,  // mask to load
    output logic            take_out,     // exception start pulse
    output logic      [3:0] mask_out      // status mask level
);
    logic [4:0] cnt_r;
    logic [3:0] lvl_r;
    // wait the decode latency, then replace the instruction
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            take_out <= 1'b0;
            mask_out <= 4'h0;
            cnt_r    <= 5'h00;
            lvl_r    <= 4'h0;
        end else begin
            take_out <= 1'b0;
            if (mask_ld_in)
                mask_out <= mask_val_in;
            else if (take_out)
                mask_out <= lvl_r;
            if (cnt_r > 5'h01)
                cnt_r <= cnt_r - 5'h01;
            else if (cnt_r == 5'h01) begin
                // a withdrawn request is never taken; stacking and
                // vector fetch use no cycles at these ports
                take_out <= int_req_in;
                lvl_r    <= int_level_in;
                cnt_r    <= 5'h00;
            end else if (go_in && int_req_in)
                cnt_r <= {1'b0, dly_in} + 5'h01;
        end
    end
endmodule
`default_nettype wire

// ==== verification/pic_ctrl_tb.sv ====
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; \
    if ((s) !== (e)) begin bad_count++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module pic_ctrl_tb;
    import pic_pkg::*;
    logic        mclk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic        wr_en, rd_en, nmi, take, go, mask_ld, req, ack_n, ce;
    logic [2:0]  addr;
    logic [15:0] wdat, rdat, v;
    logic [7:0]  pins;
    logic [29:0] pq;
    logic [3:0]  mask, mval, lvl, dly;
    logic [5:0]  src;
    logic [15:0] pr [5];
    int          bad_count = 0;
    int          comparisons = 0;
    // free-running system clock
    always #20 mclk_in = ~mclk_in;
    pic_ctrl DUT (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ce_in(ce),
        .addr_in(addr), .wr_data_in(wdat), .wr_en_in(wr_en),
        .rd_en_in(rd_en), .rd_data_out(rdat), .ext_req_n_in(pins),
        .nmi_in(nmi), .periph_req_in(pq), .cpu_mask_level_in(mask),
        .cpu_take_in(take), .int_req_out(req), .int_level_out(lvl),
        .int_src_out(src), .irq_ack_out_n(ack_n));
    pic_cpu_model CPU (.clk_in(mclk_in), .rst_in(sys_rst_in),
        .int_req_in(req), .int_level_in(lvl), .go_in(go), .dly_in(dly),
        .mask_ld_in(mask_ld), .mask_val_in(mval), .take_out(take),
        .mask_out(mask));
    // register port cycles, shadow kept for expectations
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        addr <= a; wdat <= d; wr_en <= 1'b1;
        @(posedge mclk_in);
        wr_en <= 1'b0;
        if (a < 3'h5) pr[a] = (a == 3'h4) ? (d & PIC_PRIO_E_WMASK) : d;
    endtask
    // write, then read back on the very next cycle
    task automatic wrrd(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        addr <= a;
        wdat <= d;
        wr_en <= 1'b1;
        @(posedge mclk_in);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        @(posedge mclk_in);
        rd_en <= 1'b0;
        pr[a] = d;
        #1 `CHK("rd_data", d, rdat)
    endtask
    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        @(posedge mclk_in);
        addr <= a; rd_en <= 1'b1;
        @(posedge mclk_in);
        rd_en <= 1'b0;
        #1 `CHK("rd_data", e, rdat)
    endtask
    task automatic setmask(input logic [3:0] m);
        @(posedge mclk_in);
        mask_ld <= 1'b1; mval <= m;
        @(posedge mclk_in);
        mask_ld <= 1'b0;
    endtask
    // bounded wait for the forwarded request to reach a value
    task automatic wreq(input logic e);
        int i;
        i = 0;
        while (req !== e && i < 20) begin
            @(posedge mclk_in); #1; i++;
        end
        `CHK("int_req", e, req)
        if (req !== e) end_of_test();
    endtask
    // level field of a peripheral bit
    function automatic logic [3:0] plev(input int b);
        int f;
        f = b < 4 ? 8 + b / 2 : b < 19 ? 10 + (b - 4) / 3 :
            b < 27 ? 15 + (b - 19) / 4 : (b == 29 ? 18 : b - 10);
        return pr[f / 4][15 - 4 * (f % 4) -: 4];
    endfunction
    task automatic expect_win();
        int bs;
        logic [3:0] bl;
        logic e;
        bs = -1; bl = 4'h0;
        for (int b = 0; b < 30; b++)
            if (pq[b] && (bs < 0 || plev(b) > bl)) begin
                bs = b; bl = plev(b);
            end
        e = bs >= 0 && bl > mask;
        `CHK("int_req", e, req)
        `CHK("ack_n", !e, ack_n)
        if (e) `CHK("int_src", 6'(bs + 9), src)
        if (e) `CHK("int_level", bl, lvl)
    endtask
    task end_of_test;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // cut a hang short
    initial begin
        repeat (100000) @(posedge mclk_in);
        bad_count++;
        end_of_test();
    end
    // main sequence
    initial begin
        addr = 3'h0; wdat = 16'h0000; wr_en = 1'b0; rd_en = 1'b0;
        pins = 8'hFF; nmi = 1'b1; pq = 30'h0; go = 1'b0; dly = 4'h2;
        mask_ld = 1'b0; mval = 4'h0; ce = 1'b1;
        for (int i = 0; i < 5; i++) pr[i] = 16'h0000;
        void'($urandom(32'hDECC));
        repeat (5) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        for (int a = 0; a < 8; a++)
            rd(3'(a), a == 5 ? 16'h8000 : 16'h0000);
        $display("reset values done");
        for (int a = 0; a < 4; a++) begin
            v = 16'($urandom);
            wrrd(3'(a), v);
        end
        wr(3'h4, 16'hFFF0);
        rd(3'h4, 16'hFFF0);
        wr(3'h5, 16'h01FF);
        rd(3'h5, 16'h81FF);
        wr(3'h6, 16'hFFFF);
        rd(3'h6, 16'h0000);
        wr(3'h5, 16'h0000);
        // a write while the clock enable is low must be ignored
        @(posedge mclk_in);
        ce <= 1'b0;
        addr <= 3'h0;
        wdat <= ~pr[0];
        wr_en <= 1'b1;
        @(posedge mclk_in);
        wr_en <= 1'b0;
        ce <= 1'b1;
        rd(3'h0, pr[0]);
        $display("register access done");
        for (int n = 0; n < 40; n++) begin
            v = {4{4'($urandom)}};
            for (int a = 0; a < 5; a++)
                wr(3'(a), (n % 4 == 0 ? v : 16'($urandom)) &
                   (a == 4 ? 16'hFFF0 : 16'hFFFF));
            @(posedge mclk_in);
            pq <= 30'($urandom & $urandom & $urandom);
            setmask(4'($urandom));
            repeat (2) @(posedge mclk_in);
            #1 expect_win();
        end
        pq <= 30'h0;
        $display("arbitration done");
        wr(3'h2, 16'hF000);
        setmask(4'h0);
        dly <= 4'(2 + $urandom % 8);
        pq <= 30'h1;
        go <= 1'b1;
        wreq(1'b1);
        wreq(1'b0);
        `CHK("ack_n", 1'b1, ack_n)
        go <= 1'b0;
        pq <= 30'h0;
        setmask(4'h0);
        wr(3'h0, 16'hF000);
        pins <= 8'hFE;
        wreq(1'b1);
        `CHK("int_src", 6'h01, src)
        pins <= 8'hFF;
        wreq(1'b0);
        $display("acceptance and level pin done");
        wr(3'h5, 16'h0080);
        pins <= 8'hFE;
        repeat (4) @(posedge mclk_in);
        pins <= 8'hFF;
        wreq(1'b1);
        `CHK("int_src", 6'h01, src)
        go <= 1'b1;
        wreq(1'b0);
        go <= 1'b0;
        setmask(4'h0);
        repeat (6) @(posedge mclk_in);
        #1 `CHK("int_req", 1'b0, req)
        $display("edge pin done");
        nmi <= 1'b0;
        wreq(1'b1);
        `CHK("int_src", PIC_SRC_NMI, src)
        `CHK("int_level", PIC_NMI_LEVEL, lvl)
        rd(3'h5, 16'h0080);
        go <= 1'b1;
        wreq(1'b0);
        go <= 1'b0;
        setmask(4'h0);
        nmi <= 1'b1;
        repeat (8) @(posedge mclk_in);
        #1 `CHK("int_req", 1'b0, req)
        wr(3'h5, 16'h0100);
        nmi <= 1'b0;
        repeat (8) @(posedge mclk_in);
        #1 `CHK("int_req", 1'b0, req)
        nmi <= 1'b1;
        wreq(1'b1);
        $display("nmi edges done");
        end_of_test();
    end
endmodule
`default_nettype wire
